//--- rtl/tws_serial_port.sv
// tws_serial_port: eight-bit three-wire serial port with its two registers
// What this block does
// - eight bits per transfer over three lines
// - most significant bit always first
// - send and receive in same transfer
// - eight-bit parallel/serial shift register
// - shift register only byte accessed
// - reset clears shift register
// - enable set: data access starts transfer
// - send written byte, collect input bits
// - enable clear: stop, clear counter, port pins
// - mode zero write starts, one read starts
// - receive-only leaves output pin undriven
// - clock select: external, div 4/8/16
// - control register bit and byte writable
// - reset clears control register
// - shift and present bit on falling edge
// - sample input on rising edge
// - stop after eighth bit, set done flag
// - internal clock stops high after transfer
`timescale 1ns/1ps
`default_nettype none
module tws_serial_port
	import tws_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic [15:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic sfr_bit_op,
	input wire logic [2:0] sfr_bit_sel,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	output logic sfr_hit,
	input wire logic serial_clock_pin_in,
	output logic serial_clock_pin_out,
	output logic serial_clock_pin_oe,
	output logic serial_out_pin,
	output logic serial_out_pin_oe,
	input wire logic serial_in_pin,
	output logic serial_pins_port_mode,
	output logic serial_out_port_mode,
	output logic xfer_done_pulse,
	output logic xfer_busy
);
	logic [7:0] mode_q;
	logic [7:0] shift_q;
	logic [7:0] shift_d;
	logic [3:0] bit_cnt_q;
	logic out_q;
	logic in_q;
	logic done_q;
	tws_state_type state_q;
	logic serial_op_enable;
	logic receive_only_select;
	logic [1:0] clk_sel;
	logic mode_sel;
	logic shift_sel;
	logic start;
	logic run;
	logic sclk_level;
	logic fall_stb;
	logic rise_stb;
	logic [7:0] mode_wval;
	logic last_fall;
	logic shift_wr;

	////////////////////////////////////////////////////////////////////////
	// decode of the two registers
	assign serial_op_enable = mode_q[TWS_BIT_OP_ENABLE];
	assign receive_only_select = mode_q[TWS_BIT_RX_ONLY];
	assign clk_sel = {mode_q[TWS_BIT_CLK_SEL_HI], mode_q[TWS_BIT_CLK_SEL_LO]};
	assign mode_sel = (sfr_addr == TWS_ADDR_MODE_CONTROL);
	assign shift_sel = (sfr_addr == TWS_ADDR_SHIFT_DATA);
	assign sfr_hit = mode_sel || shift_sel;

	// start trigger depends on mode; bit operations never reach the shifter
	assign start = serial_op_enable && (state_q == TWS_IDLE) && shift_sel && !sfr_bit_op
		&& (receive_only_select ? sfr_rd : sfr_wr);
	assign run = (state_q == TWS_SHIFT);

	// idle byte writes always land, even when disabled; mid-transfer writes are dropped
	assign shift_wr = sfr_wr && shift_sel && !sfr_bit_op && !run;

	////////////////////////////////////////////////////////////////////////
	// control register: byte write or single-bit set/clear
	always_comb
	begin
		mode_wval = mode_q;
		if (sfr_bit_op)
			mode_wval[sfr_bit_sel] = sfr_wdata[0];
		else
			mode_wval = sfr_wdata;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			mode_q <= TWS_MODE_RESET;
		else if (sfr_wr && mode_sel)
			mode_q <= mode_wval & TWS_MODE_WRITE_MASK;
	end

	////////////////////////////////////////////////////////////////////////
	tws_clkgen u_clkgen (
		.clk(clk),
		.srst(srst),
		.run(run),
		.clk_sel(clk_sel),
		.ext_clk(serial_clock_pin_in),
		.sclk_level(sclk_level),
		.fall_stb(fall_stb),
		.rise_stb(rise_stb)
	);

	// eighth rising edge ends the transfer after its last sample
	assign last_fall = rise_stb && (bit_cnt_q == TWS_BITS_PER_XFER - 4'h1);

	// transfer state; clearing the enable aborts at once
	always_ff @(posedge clk)
	begin
		if (srst || !serial_op_enable)
			state_q <= TWS_IDLE;
		else
		begin
			unique case (state_q)
				TWS_IDLE:
				begin
					if (start)
						state_q <= TWS_SHIFT;
				end
				TWS_SHIFT:
				begin
					if (last_fall)
						state_q <= TWS_IDLE;
				end
			endcase
		end
	end

	// bit counter counts sampled bits, held clear when disabled
	always_ff @(posedge clk)
	begin
		if (srst || !serial_op_enable || start)
			bit_cnt_q <= 4'h0;
		else if (run && rise_stb)
			bit_cnt_q <= bit_cnt_q + 4'h1;
	end

	////////////////////////////////////////////////////////////////////////
	// shift register: msb out on falling edge, input sampled on rising edge
	always_comb
	begin
		shift_d = shift_q;
		if (shift_wr)
			shift_d = sfr_wdata;
		else if (run && fall_stb && bit_cnt_q != 4'h0)
			shift_d = {shift_q[6:0], in_q};
		else if (run && last_fall)
			shift_d = {shift_q[6:0], serial_in_pin};
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			shift_q <= TWS_SHIFT_RESET;
		else
			shift_q <= shift_d;
	end

	// input bit latched on rising edge, merged into the register on the next fall; the eighth is merged at its own rise
	always_ff @(posedge clk)
	begin
		if (srst)
			in_q <= 1'b0;
		else if (run && rise_stb)
			in_q <= serial_in_pin;
	end

	// output latch takes the next msb on each falling edge after the first, and when loaded
	always_ff @(posedge clk)
	begin
		if (srst)
			out_q <= 1'b0;
		else if (shift_wr)
			out_q <= sfr_wdata[7];
		else if (run && fall_stb && bit_cnt_q != 4'h0)
			out_q <= shift_q[6];
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			done_q <= 1'b0;
		else
			done_q <= run && last_fall;
	end

	////////////////////////////////////////////////////////////////////////
	// pins and read data; output pin left to the port in receive-only
	assign serial_out_pin = out_q;
	assign serial_out_pin_oe = serial_op_enable && !receive_only_select;
	assign serial_clock_pin_out = sclk_level;
	assign serial_clock_pin_oe = serial_op_enable && (clk_sel != TWS_CLK_EXT);
	assign serial_pins_port_mode = !serial_op_enable;
	assign serial_out_port_mode = !serial_op_enable || receive_only_select;
	assign xfer_done_pulse = done_q;
	assign xfer_busy = run;

	always_comb
	begin
		if (mode_sel)
			sfr_rdata = mode_q;
		else if (shift_sel)
			sfr_rdata = shift_q;
		else
			sfr_rdata = 8'h00;
	end

	////////////////////////////////////////////////////////////////////////
	AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (srst)
		mode_q[6:3] == 4'h0)
		else $error("reserved mode bits not zero");
	AST_DISABLED_IDLE: assert property (@(posedge clk) disable iff (srst)
		!serial_op_enable |=> (bit_cnt_q == 4'h0) || serial_op_enable)
		else $error("counter not cleared while disabled");
	AST_START_BUSY: assert property (@(posedge clk) disable iff (srst)
		start |=> xfer_busy)
		else $error("start did not begin a transfer");
	AST_DONE_AFTER_EIGHT: assert property (@(posedge clk) disable iff (srst)
		done_q |-> $past(bit_cnt_q) == 4'h7)
		else $error("done without eight bits");
	AST_NO_OUT_RX_ONLY: assert property (@(posedge clk) disable iff (srst)
		receive_only_select |-> !serial_out_pin_oe)
		else $error("output driven in receive-only mode");
	AST_LOAD_MSB: assert property (@(posedge clk) disable iff (srst)
		(start && !receive_only_select) |=> serial_out_pin == $past(sfr_wdata[7]))
		else $error("first bit is not msb");
	AST_IDLE_CLK_HIGH: assert property (@(posedge clk) disable iff (srst)
		(!xfer_busy && clk_sel != TWS_CLK_EXT) |=> !xfer_busy || serial_clock_pin_out)
		else $error("internal clock not high when idle");
	AST_RX_ONLY_READ_START: assert property (@(posedge clk) disable iff (srst)
		(receive_only_select && sfr_wr && shift_sel && !xfer_busy) |=> !xfer_busy)
		else $error("write started transfer in receive-only mode");
	AST_FALL_SHIFT: assert property (@(posedge clk) disable iff (srst)
		(run && fall_stb && bit_cnt_q != 4'h0 && !start) |=> shift_q == {$past(shift_q[6:0]), $past(in_q)})
		else $error("shift on falling edge wrong");
endmodule : tws_serial_port
`default_nettype wire

//--- rtl/tws_pkg.sv
// tws_pkg: constants shared by the three-wire serial port
package tws_pkg;
	// special function register addresses
	localparam logic [15:0] TWS_ADDR_MODE_CONTROL = 16'hffa8;
	localparam logic [15:0] TWS_ADDR_SHIFT_DATA = 16'hffa9;
	// mode/control field positions
	localparam int TWS_BIT_OP_ENABLE = 7;
	localparam int TWS_BIT_RX_ONLY = 2;
	localparam int TWS_BIT_CLK_SEL_HI = 1;
	localparam int TWS_BIT_CLK_SEL_LO = 0;
	localparam logic [7:0] TWS_MODE_WRITE_MASK = 8'h87;
	// reset values
	localparam logic [7:0] TWS_MODE_RESET = 8'h00;
	localparam logic [7:0] TWS_SHIFT_RESET = 8'h00;
	// clock select codes
	localparam logic [1:0] TWS_CLK_EXT = 2'h0;
	localparam logic [1:0] TWS_CLK_DIV4 = 2'h1;
	localparam logic [1:0] TWS_CLK_DIV8 = 2'h2;
	localparam logic [1:0] TWS_CLK_DIV16 = 2'h3;
	// half periods of the internal serial clock less one, in clk cycles
	localparam logic [2:0] TWS_HALF_DIV4 = 3'h1;
	localparam logic [2:0] TWS_HALF_DIV8 = 3'h3;
	localparam logic [2:0] TWS_HALF_DIV16 = 3'h7;
	// bits per transfer
	localparam logic [3:0] TWS_BITS_PER_XFER = 4'h8;
	// transfer states
	typedef enum logic [1:0] {
		TWS_IDLE = 2'b01,
		TWS_SHIFT = 2'b10
	} tws_state_type;
endpackage : tws_pkg

//--- rtl/tws_clkgen.sv
// tws_clkgen: internal serial clock divider and edge strobes
`timescale 1ns/1ps
`default_nettype none
module tws_clkgen
	import tws_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic run,
	input wire logic [1:0] clk_sel,
	input wire logic ext_clk,
	output logic sclk_level,
	output logic fall_stb,
	output logic rise_stb
);
	logic [2:0] cnt_q;
	logic int_clk_q;
	logic ext_prev_q;
	logic [2:0] half;
	logic tick;

	////////////////////////////////////////////////////////////////////////
	// half period from select; divide by 4, 8 or 16
	always_comb
	begin
		unique case (clk_sel)
			TWS_CLK_DIV4: half = TWS_HALF_DIV4;
			TWS_CLK_DIV8: half = TWS_HALF_DIV8;
			default: half = TWS_HALF_DIV16;
		endcase
	end
	assign tick = run && (clk_sel != TWS_CLK_EXT) && (cnt_q == half);

	// counter restarts when idle so the first edge comes a full half later
	always_ff @(posedge clk)
	begin
		if (srst || !run || tick)
			cnt_q <= 3'h0;
		else
			cnt_q <= cnt_q + 3'h1;
	end

	// internal clock idles high between transfers
	always_ff @(posedge clk)
	begin
		if (srst || !run)
			int_clk_q <= 1'b1;
		else if (tick)
			int_clk_q <= ~int_clk_q;
	end

	// external clock is already synchronous; remember last level for edges
	always_ff @(posedge clk)
	begin
		if (srst)
			ext_prev_q <= 1'b1;
		else
			ext_prev_q <= ext_clk;
	end

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		if (clk_sel == TWS_CLK_EXT)
		begin
			sclk_level = ext_clk;
			fall_stb = run && ext_prev_q && !ext_clk;
			rise_stb = run && !ext_prev_q && ext_clk;
		end
		else
		begin
			sclk_level = int_clk_q;
			fall_stb = tick && int_clk_q;
			rise_stb = tick && !int_clk_q;
		end
	end
endmodule : tws_clkgen
`default_nettype wire

//--- testbench/tws_periph_model.sv
// tws_periph_model: far-end clocked serial device facing the port
`timescale 1ns/1ps
`default_nettype none
module tws_periph_model (
	input wire logic clk,
	input wire logic sclk,
	input wire logic sdo,
	input wire logic [7:0] tx_byte,
	input wire logic load,
	input wire logic ext_go,
	output logic sdi,
	output logic ext_clk,
	output logic [7:0] rx_byte,
	output logic [3:0] n_rise
);
	logic [7:0] tx_q = 8'h00;
	logic [7:0] rx_q = 8'h00;
	logic [3:0] cnt_q = 4'h0;
	logic [4:0] ph_q = 5'h00;
	logic [1:0] div_q = 2'h0;
	logic sclk_q = 1'b1;
	logic ext_q = 1'b1;
	logic junk_q = 1'b0;
	////////////////////////////////////////////////////////////////
	// first bit is preloaded, so the first falling edge moves nothing
	always @(posedge clk)
	begin
		sclk_q <= sclk;
		junk_q <= ~junk_q;
		if (load)
		begin
			tx_q <= tx_byte;
			cnt_q <= 4'h0;
		end
		else if (sclk_q && !sclk && cnt_q != 4'h0)
			tx_q <= {tx_q[6:0], 1'b0}; // msb first, moves on falling edge
		else if (!sclk_q && sclk)
		begin
			rx_q <= {rx_q[6:0], sdo}; // taken on rising edge
			cnt_q <= cnt_q + 4'h1;
		end
	end
	// past the eighth bit the line is not held: show a changing level
	assign sdi = (cnt_q == 4'h8) ? junk_q : tx_q[7];
	assign rx_byte = rx_q;
	assign n_rise = cnt_q;
	assign ext_clk = ext_q;
	////////////////////////////////////////////////////////////////
	// external clock: eight slow pulses, idle high between frames
	always @(posedge clk)
	begin
		div_q <= div_q + 2'h1;
		if (ext_go)
			ph_q <= 5'h10;
		else if (ph_q != 5'h00 && div_q == 2'h3)
		begin
			ph_q <= ph_q - 5'h01;
			ext_q <= ~ext_q;
		end
	end
endmodule : tws_periph_model
`default_nettype wire

//--- testbench/tb_tws_serial_port.sv
// tb_tws_serial_port: self-checking bench for the three-wire serial port
`timescale 1ns/1ps
`default_nettype none
module tb_tws_serial_port;
	import tws_pkg::*;
	typedef struct packed {logic [7:0] mode; logic [7:0] tx; logic [7:0] px;} tws_row_type;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic bop = 1'b0;
	logic pld = 1'b0;
	logic pgo = 1'b0;
	logic [15:0] adr = 16'h0000;
	logic [2:0] bsel = 3'h0;
	logic [7:0] wd = 8'h00;
	logic [7:0] ptx = 8'h00;
	wire logic [7:0] rdat;
	wire logic [7:0] prx;
	wire logic [3:0] nr;
	wire logic hit, sco, scoe, sdo, sdoe, sdi, pm, opm, done, busy, ext, sclk;
	int n_mismatch = 0;
	int checks = 0;
	// rows: mode byte, byte sent, byte the far side sends back
	tws_row_type rows [6] = '{'{8'h81, 8'ha5, 8'h3c}, '{8'h82, 8'h01, 8'h80},
		'{8'h83, 8'hff, 8'h00}, '{8'h80, 8'h5a, 8'hc3}, '{8'h85, 8'h00, 8'h96},
		'{8'h84, 8'h00, 8'h69}};
	// the clock wire is ours while enabled on internal clock, else the far side's
	assign sclk = scoe ? sco : ext;
	tws_serial_port uut (.clk(clk), .srst(srst), .sfr_addr(adr), .sfr_wr(wr), .sfr_rd(rd),
		.sfr_bit_op(bop), .sfr_bit_sel(bsel), .sfr_wdata(wd), .sfr_rdata(rdat), .sfr_hit(hit),
		.serial_clock_pin_in(ext), .serial_clock_pin_out(sco), .serial_clock_pin_oe(scoe),
		.serial_out_pin(sdo), .serial_out_pin_oe(sdoe), .serial_in_pin(sdi),
		.serial_pins_port_mode(pm), .serial_out_port_mode(opm), .xfer_done_pulse(done),
		.xfer_busy(busy));
	tws_periph_model periph (.clk(clk), .sclk(sclk), .sdo(sdo), .tx_byte(ptx), .load(pld),
		.ext_go(pgo), .sdi(sdi), .ext_clk(ext), .rx_byte(prx), .n_rise(nr));
	////////////////////////////////////////////////////////////////
	// 40 MHz clock
	initial
	begin
		forever #12.5 clk = ~clk;
	end
	task automatic report_and_stop();
		if (n_mismatch == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %0t ns: saw %h, wanted %h", $time, got, exp);
		end
	endtask : chk
	// one strobed access, held across exactly one rising edge
	task automatic acc(input logic [15:0] a, input logic w, input logic r, input logic [7:0] d);
		@(negedge clk);
		adr = a;
		wd = d;
		wr = w;
		rd = r;
		@(negedge clk);
		wr = 1'b0;
		rd = 1'b0;
	endtask : acc
	// read data is combinational, so no strobe and no transfer start
	task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
		@(negedge clk);
		adr = a;
		#1 chk(rdat, e);
	endtask : rdchk
	// bounded wait: a lost done pulse ends the run
	task automatic wait_done(output int n);
		for (n = 0; n < 400 && done !== 1'b1; n++)
			@(negedge clk);
		if (n == 400)
		begin
			n_mismatch++;
			report_and_stop();
		end
	endtask : wait_done
	task automatic xfer(input tws_row_type r);
		int cyc;
		ptx = r.px;
		pld = 1'b1;
		acc(TWS_ADDR_MODE_CONTROL, 1'b1, 1'b0, r.mode);
		pld = 1'b0;
		acc(TWS_ADDR_SHIFT_DATA, !r.mode[2], r.mode[2], r.tx);
		chk({7'h00, busy}, 8'h01);
		chk({7'h00, sdoe}, {7'h00, !r.mode[2]});
		chk({6'h00, pm, opm}, {7'h00, r.mode[2]});
		if (r.mode[1:0] == TWS_CLK_EXT)
		begin
			pgo = 1'b1;
			@(negedge clk);
			pgo = 1'b0;
		end
		// no shift register access until the frame is over
		wait_done(cyc);
		// eight serial periods of 4, 8 or 16 clocks on the internal clock
		if (r.mode[1:0] != TWS_CLK_EXT)
			chk(cyc[7:0], 8'h08 << ({1'b0, r.mode[1:0]} + 3'h1));
		@(negedge clk);
		chk({6'h00, busy, sclk}, 8'h01);
		chk({4'h0, nr}, 8'h08);
		rdchk(TWS_ADDR_SHIFT_DATA, r.px);
		if (!r.mode[2])
			chk(prx, r.tx);
	endtask : xfer
	////////////////////////////////////////////////////////////////
	// main sequence: reset, table of transfers, then the awkward cases
	initial
	begin
		repeat (6) @(negedge clk);
		srst = 1'b0;
		rdchk(TWS_ADDR_MODE_CONTROL, 8'h00);
		rdchk(TWS_ADDR_SHIFT_DATA, 8'h00);
		chk({6'h00, pm, opm}, 8'h03);
		foreach (rows[i])
			xfer(rows[i]);
		acc(TWS_ADDR_MODE_CONTROL, 1'b1, 1'b0, 8'h7c);
		rdchk(TWS_ADDR_MODE_CONTROL, 8'h04);
		bop = 1'b1;
		bsel = 3'h7;
		acc(TWS_ADDR_MODE_CONTROL, 1'b1, 1'b0, 8'h01);
		rdchk(TWS_ADDR_MODE_CONTROL, 8'h84);
		bsel = 3'h2;
		acc(TWS_ADDR_MODE_CONTROL, 1'b1, 1'b0, 8'h00);
		rdchk(TWS_ADDR_MODE_CONTROL, 8'h80);
		acc(TWS_ADDR_SHIFT_DATA, 1'b1, 1'b0, 8'hff);
		chk({7'h00, busy}, 8'h00);
		rdchk(TWS_ADDR_SHIFT_DATA, 8'h69);
		bop = 1'b0;
		acc(TWS_ADDR_MODE_CONTROL, 1'b1, 1'b0, 8'h01);
		acc(TWS_ADDR_SHIFT_DATA, 1'b1, 1'b0, 8'h3c);
		chk({7'h00, busy}, 8'h00);
		rdchk(TWS_ADDR_SHIFT_DATA, 8'h3c);
		acc(TWS_ADDR_MODE_CONTROL, 1'b1, 1'b0, 8'h81);
		acc(TWS_ADDR_SHIFT_DATA, 1'b1, 1'b0, 8'hc3);
		repeat (6) @(negedge clk);
		acc(TWS_ADDR_MODE_CONTROL, 1'b1, 1'b0, 8'h01);
		@(negedge clk);
		chk({4'h0, busy, pm, scoe, sdoe}, 8'h04);
		xfer('{8'h81, 8'h96, 8'h5a});
		// reset in the middle of a frame
		acc(TWS_ADDR_SHIFT_DATA, 1'b1, 1'b0, 8'h3c);
		srst = 1'b1;
		repeat (2) @(negedge clk);
		srst = 1'b0;
		rdchk(TWS_ADDR_MODE_CONTROL, 8'h00);
		rdchk(TWS_ADDR_SHIFT_DATA, 8'h00);
		chk({7'h00, hit}, 8'h01);
		chk({2'h0, busy, pm, opm, scoe, sdoe, sclk}, 8'h19);
		rdchk(16'hffa7, 8'h00);
		chk({7'h00, hit}, 8'h00);
		report_and_stop();
	end
endmodule : tb_tws_serial_port
`default_nettype wire
